// ===== rtl/swm_sweep_ctrl.sv
/*
  Sweep mode control: decodes the control word, steps a frequency index
  through saw or triangular profiles, chooses the increment and burst
  sources and drives the sync output pin. Registers over AXI4-Lite.
  Assumes one aclk domain; the trigger pin is asynchronous.
*/
`timescale 1ns/1ps
// How it works
// R1 - With increment source set, steps advance only on external trigger edges.
// R2 - With increment source clear, steps advance from the internal step timer.
// R3 - Profile bit set gives saw: climb to end, then restart at start.
// R4 - Profile bit clear gives triangle: climb to end, then step back down.
// R5 - Sync select only matters while the sync output enable bit is one.
// R6 - Sync select set: pin goes high at sweep end, low at next sweep start.
// R7 - Burst interval counts either clock periods or output waveform cycles.
// R8 - Burst source bit is ignored while increment source is internal.
// R9 - External increments with burst source set: trigger also ends bursts.
// R10 - External increments with burst source clear: bursts timed from register.
// R11 - Sync select clear, sync enabled: one pulse per frequency increment.
module swm_sweep_ctrl
#(
  parameter int unsigned IDX_W = 16
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger_pin,
  input wire logic wave_cycle_tick,
  output logic sync_output_pin,
  output logic [IDX_W-1:0] freq_index,
  output logic burst_active
);
  initial
  begin
    if (IDX_W < 2 || IDX_W > 16)
    begin
      $error("IDX_W must lie between 2 and 16");
    end
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] num_steps;
    logic [15:0] step_time;
    logic [15:0] burst_time;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    swm_pkg::swm_state_e state;
    logic [IDX_W-1:0] idx;
    logic down;
    logic [15:0] timer;
    logic sync;
    logic sweep_done;
  } swm_ctrl_s;
  swm_ctrl_s st_reg;
  swm_ctrl_s st_next;

  logic trig_level;
  logic trig_rise;

  swm_pin_sync u_trig_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(trigger_pin),
    .level(trig_level),
    .rise(trig_rise)
  );

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  logic run;
  logic sync_en;
  logic sync_sel;
  logic saw;
  logic ext_incr;
  logic ext_burst;
  logic burst_cycles;
  logic advance;
  logic burst_end;
  logic [IDX_W-1:0] last_idx;
  logic step_evt;

  assign run = st_reg.ctrl[swm_pkg::BIT_RUN];
  assign sync_en = st_reg.ctrl[swm_pkg::BIT_SYNC_EN];
  assign sync_sel = st_reg.ctrl[swm_pkg::BIT_SYNC_SEL];
  assign saw = st_reg.ctrl[swm_pkg::BIT_PROFILE];
  assign ext_incr = st_reg.ctrl[swm_pkg::BIT_INCR_SRC];
  // Burst source only counts under external increments.
  assign ext_burst = ext_incr & st_reg.ctrl[swm_pkg::BIT_BURST_SRC]; // R8
  assign burst_cycles = st_reg.ctrl[swm_pkg::BIT_BURST_UNIT];
  assign last_idx = st_reg.num_steps[IDX_W-1:0];

  always_comb
  begin
    st_next = st_reg;
    advance = 1'b0;
    burst_end = 1'b0;
    step_evt = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data taken in either order.
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = swm_pkg::RESP_OKAY;
      case ({st_reg.aw_addr[7:2], 2'h0})
        swm_pkg::OFS_CTRL:
          st_next.ctrl = merge_strb(st_reg.ctrl, st_reg.w_data, st_reg.w_strb);
        swm_pkg::OFS_NUM_STEPS:
          st_next.num_steps = 16'(merge_strb({16'h0000, st_reg.num_steps},
                                             st_reg.w_data, st_reg.w_strb));
        swm_pkg::OFS_STEP_TIME:
          st_next.step_time = 16'(merge_strb({16'h0000, st_reg.step_time},
                                             st_reg.w_data, st_reg.w_strb));
        swm_pkg::OFS_BURST_TIME:
          st_next.burst_time = 16'(merge_strb({16'h0000, st_reg.burst_time},
                                              st_reg.w_data, st_reg.w_strb));
        default:
          st_next.bresp = swm_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = swm_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'h0})
        swm_pkg::OFS_CTRL: st_next.rdata = st_reg.ctrl;
        swm_pkg::OFS_NUM_STEPS: st_next.rdata = {16'h0000, st_reg.num_steps};
        swm_pkg::OFS_STEP_TIME: st_next.rdata = {16'h0000, st_reg.step_time};
        swm_pkg::OFS_BURST_TIME: st_next.rdata = {16'h0000, st_reg.burst_time};
        swm_pkg::OFS_STATUS:
          st_next.rdata = {8'h00, 16'(st_reg.idx), st_reg.down, st_reg.sweep_done,
                           st_reg.sync, trig_level, 1'b0, st_reg.state};
        swm_pkg::OFS_ID: st_next.rdata = swm_pkg::BLOCK_ID;
        default:
        begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = swm_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sweep sequencer.
    case (st_reg.state)
      swm_pkg::SWM_IDLE:
      begin
        st_next.idx = '0;
        st_next.down = 1'b0;
        st_next.timer = st_reg.step_time;
        if (run)
        begin
          st_next.state = swm_pkg::SWM_STEP;
          st_next.sweep_done = 1'b0;
        end
      end
      swm_pkg::SWM_STEP:
      begin
        if (ext_incr)
        begin
          advance = trig_rise; // R1
        end
        else
        begin
          advance = (st_reg.timer <= 16'h0001); // R2
          st_next.timer = advance ? st_reg.step_time : st_reg.timer - 16'h0001;
        end
        if (advance)
        begin
          st_next.state = swm_pkg::SWM_BURST;
          st_next.timer = st_reg.burst_time;
        end
      end
      swm_pkg::SWM_BURST:
      begin
        // Idle gap after a step: ends by trigger or by the interval count.
        if (ext_burst)
        begin
          burst_end = trig_rise; // R9
        end
        else
        begin
          burst_end = (st_reg.timer == 16'h0000); // R10
          if (!burst_end && (!burst_cycles || wave_cycle_tick))
          begin
            st_next.timer = st_reg.timer - 16'h0001; // R7
          end
        end
        if (burst_end)
        begin
          step_evt = 1'b1;
          st_next.state = swm_pkg::SWM_STEP;
          st_next.timer = st_reg.step_time;
          if (st_reg.sweep_done)
          begin
            st_next.sweep_done = 1'b0;
          end
          if (!st_reg.down && st_reg.idx >= last_idx)
          begin
            if (saw)
            begin
              st_next.idx = '0; // R3
              st_next.sweep_done = 1'b1;
            end
            else
            begin
              st_next.down = 1'b1; // R4
              st_next.idx = st_reg.idx - 1'b1;
            end
          end
          else if (st_reg.down)
          begin
            st_next.idx = st_reg.idx - 1'b1; // R4
            if (st_reg.idx == IDX_W'(1))
            begin
              st_next.down = 1'b0;
              st_next.sweep_done = 1'b1;
            end
          end
          else
          begin
            st_next.idx = st_reg.idx + 1'b1;
          end
        end
      end
      default:
        st_next.state = swm_pkg::SWM_IDLE;
    endcase
    if (!run)
    begin
      st_next.state = swm_pkg::SWM_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sync output pin.
    if (!sync_en)
    begin
      st_next.sync = 1'b0; // R5
    end
    else if (sync_sel)
    begin
      st_next.sync = st_next.sweep_done; // R6
    end
    else
    begin
      st_next.sync = step_evt; // R11
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.ctrl <= swm_pkg::CTRL_RESET;
      st_reg.num_steps <= swm_pkg::NUM_STEPS_RESET;
      st_reg.step_time <= swm_pkg::STEP_TIME_RESET;
      st_reg.burst_time <= swm_pkg::BURST_TIME_RESET;
      st_reg.state <= swm_pkg::SWM_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = ~st_reg.aw_got;
  assign s_axi_wready = ~st_reg.w_got;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = ~st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign sync_output_pin = st_reg.sync;
  assign freq_index = st_reg.idx;
  assign burst_active = (st_reg.state == swm_pkg::SWM_STEP);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_ext_step;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.state == swm_pkg::SWM_STEP && ext_incr && run && !trig_rise)
      |=> st_reg.state == swm_pkg::SWM_STEP;
  endproperty
  a_ext_step: assert property (p_ext_step) else $error("step left without trigger"); // R1

  property p_int_step;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.state == swm_pkg::SWM_STEP && !ext_incr && run && st_reg.timer == 16'h0001)
      |=> st_reg.state == swm_pkg::SWM_BURST;
  endproperty
  a_int_step: assert property (p_int_step) else $error("timer expiry did not step"); // R2

  property p_saw;
    @(posedge aclk) disable iff (!aresetn)
    (burst_end && run && saw && !st_reg.down && st_reg.idx >= last_idx)
      |=> st_reg.idx == '0;
  endproperty
  a_saw: assert property (p_saw) else $error("saw did not restart"); // R3

  property p_tri;
    @(posedge aclk) disable iff (!aresetn)
    (burst_end && run && !saw && !st_reg.down && st_reg.idx >= last_idx)
      |=> st_reg.down && st_reg.idx == $past(st_reg.idx) - 1'b1;
  endproperty
  a_tri: assert property (p_tri) else $error("triangle did not turn down"); // R4

  property p_sync_off;
    @(posedge aclk) disable iff (!aresetn)
    !sync_en |=> !sync_output_pin;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync driven while disabled"); // R5

  property p_sync_eos;
    @(posedge aclk) disable iff (!aresetn)
    (sync_en && sync_sel && $stable(st_reg.ctrl)) |-> sync_output_pin == st_reg.sweep_done;
  endproperty
  a_sync_eos: assert property (p_sync_eos) else $error("end of sweep level wrong"); // R6

  property p_burst_unit;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.state == swm_pkg::SWM_BURST && !ext_burst && burst_cycles && !wave_cycle_tick
     && st_reg.timer != 16'h0000 && run) |=> $stable(st_reg.timer);
  endproperty
  a_burst_unit: assert property (p_burst_unit) else $error("cycle burst counted clocks"); // R7

  property p_burst_ign;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.state == swm_pkg::SWM_BURST && !ext_incr && st_reg.timer == 16'h0000 && run)
      |=> st_reg.state == swm_pkg::SWM_STEP;
  endproperty
  a_burst_ign: assert property (p_burst_ign) else $error("burst source not ignored"); // R8

  property p_ext_burst;
    @(posedge aclk) disable iff (!aresetn)
    (st_reg.state == swm_pkg::SWM_BURST && ext_burst && !trig_rise && run)
      |=> st_reg.state == swm_pkg::SWM_BURST;
  endproperty
  a_ext_burst: assert property (p_ext_burst) else $error("burst ended without trigger"); // R9

  property p_inc_pulse;
    @(posedge aclk) disable iff (!aresetn)
    (sync_en && !sync_sel && step_evt) |=> sync_output_pin ##1 !sync_output_pin;
  endproperty
  a_inc_pulse: assert property (p_inc_pulse) else $error("increment pulse wrong"); // R11

  c_saw_wrap: cover property (@(posedge aclk) disable iff (!aresetn) run && saw && burst_end
    && st_reg.idx >= last_idx);
  c_tri_turn: cover property (@(posedge aclk) disable iff (!aresetn) st_reg.down
    && st_reg.idx == IDX_W'(1) && burst_end);
  c_ext_trig: cover property (@(posedge aclk) disable iff (!aresetn) ext_burst && burst_end);
endmodule : swm_sweep_ctrl

// ===== shared/swm_pkg.sv
/*
  Shared constants for the sweep mode control block: register map, control
  word field positions, reset values and sequencer defaults.
  Assumes a single 200 MHz clock domain and an AXI4-Lite register bus.
*/
package swm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_NUM_STEPS = 8'h04;
  localparam logic [7:0] OFS_STEP_TIME = 8'h08;
  localparam logic [7:0] OFS_BURST_TIME = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ID = 8'h14;
  // Control word bit positions.
  localparam int unsigned BIT_SYNC_EN = 2;
  localparam int unsigned BIT_SYNC_SEL = 3;
  localparam int unsigned BIT_PROFILE = 4;
  localparam int unsigned BIT_INCR_SRC = 5;
  localparam int unsigned BIT_BURST_SRC = 6;
  localparam int unsigned BIT_BURST_UNIT = 7;
  localparam int unsigned BIT_RUN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] NUM_STEPS_RESET = 16'h0004;
  localparam logic [15:0] STEP_TIME_RESET = 16'h0010;
  localparam logic [15:0] BURST_TIME_RESET = 16'h0008;
  // Arbitrary value, names no part.
  localparam logic [31:0] BLOCK_ID = 32'h5e3e_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    SWM_IDLE = 3'h1,
    SWM_STEP = 3'h2,
    SWM_BURST = 3'h4
  } swm_state_e;
endpackage : swm_pkg

// ===== rtl/swm_pin_sync.sv
/*
  Three-stage synchroniser with agreement filter for an external pin.
  Assumes the pin is asynchronous to aclk; rise is a one-cycle pulse.
*/
`timescale 1ns/1ps
module swm_pin_sync
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } swm_sync_s;
  swm_sync_s st_reg;
  swm_sync_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // The level follows only once the second and third stages agree.
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.lvl = st_reg.s3;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;
  assign rise = st_next.lvl & ~st_reg.lvl;
endmodule : swm_pin_sync

// ===== tb/swm_ctrl_model.sv
/*
  Model of the external controller's pins: a trigger pin and a waveform cycle tick.
  Assumes the bench asks for each trigger with a one-cycle fire request.
*/
`timescale 1ns/1ps
module swm_ctrl_model
#(
  parameter int unsigned TICK_DIV = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  output logic trigger_pin,
  output logic wave_cycle_tick
);
  logic [3:0] hold;
  logic [7:0] div;
  // The trigger stays high six cycles so the pin filter surely sees it, then low at least seven.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trigger_pin <= 1'b0;
      hold <= 4'h0;
      div <= 8'h00;
      wave_cycle_tick <= 1'b0;
    end
    else
    begin
      div <= (div == 8'(TICK_DIV - 1)) ? 8'h00 : div + 8'h01;
      wave_cycle_tick <= (div == 8'h00);
      if (fire && hold == 4'h0)
      begin
        trigger_pin <= 1'b1;
        hold <= 4'hc;
      end
      else if (hold != 4'h0)
      begin
        hold <= hold - 4'h1;
        if (hold == 4'h7)
          trigger_pin <= 1'b0;
      end
    end
  end
endmodule : swm_ctrl_model

// ===== tb/swm_sweep_ctrl_tb.sv
/*
  Self-checking bench for the sweep mode control block.
  Assumes the register map and bit positions of the shared package.
*/
`timescale 1ns/1ps
module swm_sweep_ctrl_tb;
  localparam int unsigned TD = 8;
  localparam logic [31:0] C_RUN = 32'h1 << swm_pkg::BIT_RUN;
  localparam logic [31:0] C_SEN = 32'h1 << swm_pkg::BIT_SYNC_EN;
  localparam logic [31:0] C_SSEL = 32'h1 << swm_pkg::BIT_SYNC_SEL;
  localparam logic [31:0] C_SAW = 32'h1 << swm_pkg::BIT_PROFILE;
  localparam logic [31:0] C_EXT = 32'h1 << swm_pkg::BIT_INCR_SRC;
  localparam logic [31:0] C_BEXT = 32'h1 << swm_pkg::BIT_BURST_SRC;
  localparam logic [31:0] C_WAVE = 32'h1 << swm_pkg::BIT_BURST_UNIT;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trig, tick, sync, bact, fire = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] fidx, prev_idx;
  logic idx_watch = 1'b0, stat_clr = 1'b0;
  logic [15:0] exp_idx[$];
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int err_total = 0, check_count = 0;
  int s_rise, s_hi, hi_zero, b_rise, low_run, last_low;
  logic [7:0] lfsr = 8'h16;
  logic [15:0] ns;
  always #2.5 aclk = ~aclk;
  swm_sweep_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trigger_pin(trig), .wave_cycle_tick(tick),
    .sync_output_pin(sync), .freq_index(fidx), .burst_active(bact));
  swm_ctrl_model #(.TICK_DIV(TD)) partner (.aclk(aclk), .aresetn(aresetn), .fire(fire),
    .trigger_pin(trig), .wave_cycle_tick(tick));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_v
  task automatic chk_rd(input logic [33:0] exp);
    chk_v({30'h0, rresp}, {30'h0, exp[33:32]}, "read response");
    chk_v(rdata, exp[31:0], "read data");
  endtask : chk_rd
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end
    while (!(bvalid && bready) && n < 100);
    if (n >= 100) chk_v(32'h0, 32'h1, "write hang");
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_r.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end
    while (!(rvalid && rready) && n < 100);
    if (n >= 100) chk_v(32'h0, 32'h1, "read hang");
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  task automatic do_reset();
    idx_watch <= 1'b0;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    stat_clr <= 1'b1;
    exp_idx.delete();
    @(posedge aclk);
    stat_clr <= 1'b0;
  endtask : do_reset
  task automatic setup(input logic [15:0] n, input logic [15:0] st, input logic [15:0] bt);
    axi_wr(swm_pkg::OFS_NUM_STEPS, {16'h0, n}, swm_pkg::RESP_OKAY);
    axi_wr(swm_pkg::OFS_STEP_TIME, {16'h0, st}, swm_pkg::RESP_OKAY);
    axi_wr(swm_pkg::OFS_BURST_TIME, {16'h0, bt}, swm_pkg::RESP_OKAY);
  endtask : setup
  task automatic run_seq(input logic [31:0] ctrl);
    int n;
    n = 0;
    idx_watch <= 1'b1;
    axi_wr(swm_pkg::OFS_CTRL, ctrl, swm_pkg::RESP_OKAY);
    while (exp_idx.size() != 0 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) chk_v(32'h0, 32'h1, "sweep stalled");
    repeat (3) @(posedge aclk);
  endtask : run_seq
  task automatic pulse_fire();
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (30) @(posedge aclk);
  endtask : pulse_fire
  ////////////////////////////////////////////////////////////////////////////////
  // The monitor pairs each write response, read result and index step with the oldest expectation.
  always @(posedge aclk)
  begin
    if (bvalid && bready && exp_b.size() != 0)
      chk_v({30'h0, bresp}, {30'h0, exp_b.pop_front()}, "write response");
    if (rvalid && rready && exp_r.size() != 0)
      chk_rd(exp_r.pop_front());
    if (aresetn && idx_watch && fidx !== prev_idx)
    begin
      if (exp_idx.size() == 0)
        chk_v({16'h0, fidx}, {16'h0, prev_idx}, "index moved");
      else
        chk_v({16'h0, fidx}, {16'h0, exp_idx.pop_front()}, "index step");
    end
    prev_idx <= fidx;
    if (stat_clr)
    begin
      s_rise <= 0;
      s_hi <= 0;
      hi_zero <= 0;
      b_rise <= 0;
    end
    else
    begin
      s_rise <= s_rise + int'(sync && !$past(sync));
      s_hi <= s_hi + int'(sync);
      hi_zero <= hi_zero + int'(sync && fidx == 16'h0);
      b_rise <= b_rise + int'(bact && !$past(bact));
    end
    low_run <= bact ? 0 : low_run + 1;
    if (bact && !$past(bact)) last_low <= low_run;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    do_reset();
    axi_rd(swm_pkg::OFS_CTRL, swm_pkg::CTRL_RESET, swm_pkg::RESP_OKAY);
    axi_rd(swm_pkg::OFS_NUM_STEPS, {16'h0, swm_pkg::NUM_STEPS_RESET}, swm_pkg::RESP_OKAY);
    axi_rd(swm_pkg::OFS_STEP_TIME, {16'h0, swm_pkg::STEP_TIME_RESET}, swm_pkg::RESP_OKAY);
    axi_rd(swm_pkg::OFS_BURST_TIME, {16'h0, swm_pkg::BURST_TIME_RESET}, swm_pkg::RESP_OKAY);
    axi_rd(swm_pkg::OFS_ID, swm_pkg::BLOCK_ID, swm_pkg::RESP_OKAY);
    axi_rd(swm_pkg::OFS_STATUS, {29'h0, swm_pkg::SWM_IDLE}, swm_pkg::RESP_OKAY);
    axi_rd(8'h18, 32'h0, swm_pkg::RESP_SLVERR);
    axi_wr(8'h18, 32'hffff_ffff, swm_pkg::RESP_SLVERR);
    // Saw with a random end index; the burst source bit is set but must not matter.
    lfsr = lfsr_next(lfsr);
    ns = 16'h2 + 16'(lfsr % 8'h3);
    setup(ns, 16'h4 + 16'(lfsr[2:0]), 16'h0);
    for (int i = 1; i <= int'(ns); i++) exp_idx.push_back(16'(i));
    exp_idx.push_back(16'h0);
    exp_idx.push_back(16'h1);
    run_seq(C_RUN | C_SEN | C_SSEL | C_SAW | C_BEXT);
    chk_v(32'(s_rise), 32'h1, "sweep end sync count");
    chk_v(32'(hi_zero != 0), 32'h1, "sync high at sweep end");
    chk_v({31'h0, sync}, 32'h0, "sync low in next sweep");
    // Triangle with a pulse per increment.
    do_reset();
    setup(16'h3, 16'h5, 16'h1);
    exp_idx.delete();
    exp_idx = '{16'h1, 16'h2, 16'h3, 16'h2, 16'h1, 16'h0, 16'h1};
    run_seq(C_RUN | C_SEN);
    chk_v(32'(s_rise), 32'h7, "increment pulses");
    chk_v(32'(s_hi), 32'h7, "increment pulse width");
    // Sync select without the enable leaves the pin low.
    do_reset();
    setup(16'h2, 16'h4, 16'h0);
    exp_idx = '{16'h1, 16'h2, 16'h0};
    run_seq(C_RUN | C_SSEL | C_SAW);
    chk_v(32'(s_rise), 32'h0, "sync while disabled");
    // External increments, internal burst timing.
    do_reset();
    setup(16'h2, 16'h4, 16'h3);
    run_seq(C_RUN | C_EXT | C_SAW);
    repeat (60) @(posedge aclk);
    chk_v({31'h0, bact}, 32'h1, "step held without trigger");
    exp_idx.push_back(16'h1);
    pulse_fire();
    chk_v(32'(exp_idx.size()), 32'h0, "trigger advance");
    // External increments and external burst end.
    do_reset();
    setup(16'h2, 16'h4, 16'h3);
    run_seq(C_RUN | C_EXT | C_BEXT | C_SAW);
    pulse_fire();
    repeat (40) @(posedge aclk);
    chk_v({31'h0, bact}, 32'h0, "gap held for trigger");
    exp_idx.push_back(16'h1);
    pulse_fire();
    chk_v(32'(exp_idx.size()), 32'h0, "trigger ends gap");
    // Burst interval in clocks, then in waveform cycles.
    for (int u = 0; u < 2; u++)
    begin
      do_reset();
      setup(16'h2, 16'h4, 16'h2);
      axi_wr(swm_pkg::OFS_CTRL, C_RUN | C_SAW | (u == 1 ? C_WAVE : 32'h0), swm_pkg::RESP_OKAY);
      for (int n = 0; n < 500 && b_rise < 3; n++) @(posedge aclk);
      if (u == 0)
        chk_v(32'(last_low), 32'h3, "clock gap");
      else
        chk_v(32'(last_low >= TD + 2 && last_low <= 2 * TD + 1), 32'h1, "wave gap");
    end
    tally_and_finish();
  end
endmodule : swm_sweep_ctrl_tb
